// File: inc/pgc_consts.svh
// Constants for the path gain control register bank.
`ifndef PGC_CONSTS_SVH
`define PGC_CONSTS_SVH

`define PGC_ADDR_W          8
`define PGC_DATA_W          8
`define PGC_RX_COARSE_OFS   8'h27
`define PGC_TX_FINE_OFS     8'h28
`define PGC_REG_RESET       8'h00
`define PGC_SEL_BIT         4
`define PGC_CODE_MSB        3
`define PGC_CODE_LSB        0
`define PGC_WMASK           8'h1F
`define PGC_CODE_ZERO       4'h0
`define PGC_RX_GAIN_MAX     4'hC
`define PGC_RX_SAT_PREFIX   2'h3
`define PGC_SAT_MSB         3
`define PGC_SAT_LSB         2
`define PGC_RSVD_MSB        7
`define PGC_RSVD_LSB        5
`define PGC_RSVD_ZERO       3'h0
`define PGC_CODE_ONE        4'h1
`define PGC_CODE_FULL       4'hF
`define PGC_TX_FULL_GAIN    5'h0F
`define PGC_TX_FULL_ATTEN   5'h1F

`endif

// File: inc/pgc_pkg.sv
// Types for the path gain control register bank.
`default_nettype none
package pgc_pkg;

  // Effective level applied to one path: direction and number of steps.
  typedef struct packed {
    logic       atten;
    logic [3:0] steps;
  } pgc_level_type;

endpackage
`default_nettype wire

// File: rtl/pgc_regs.sv
// Receive coarse and transmit fine gain control registers with level decode.
`timescale 1ns/1ps
`default_nettype none
`include "pgc_consts.svh"

//------------------------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------------------------
// Notes on behaviour
// - Rx select clear: higher code, more gain.
// - Rx select set: higher code, more attenuation.
// - Rx step 1 dB, max 12 gain/15 attenuation.
// - Rx code zero applies no change.
// - Rx gain codes 11xx saturate at 12 dB.
// - Rx attenuation: 0001 is 1 dB, 1111 15 dB.
// - Tx select clear gain, set attenuation.
// - Tx step 0.1 dB, max 1.5 dB.
// - Tx code zero leaves level unchanged.
// - Tx gain: 0001 adds 0.1, 1111 adds 1.5.
// - Tx attenuation: 0001 cuts 0.1, 1111 cuts 1.5.

module pgc_regs (
  input  wire logic                        CLK,
  input  wire logic                        RESETN,
  input  wire logic [`PGC_ADDR_W-1:0]      ADDR,
  input  wire logic                        WR_EN,
  input  wire logic [`PGC_DATA_W-1:0]      WR_DATA,
  output logic      [`PGC_DATA_W-1:0]      RD_DATA,
  output pgc_pkg::pgc_level_type           RX_LEVEL,
  output pgc_pkg::pgc_level_type           TX_LEVEL
);

  //----------------------------------------------------------------------------
  // Decode functions
  //----------------------------------------------------------------------------

  // Receive coarse path: steps of 1 dB, gain saturates at 12 dB.
  function automatic pgc_pkg::pgc_level_type rx_decode(
    input logic       sel,
    input logic [3:0] code
  );
    pgc_pkg::pgc_level_type lvl;
    lvl = '0;
    // A zero code reports the gain direction even with the select bit set.
    if (code == `PGC_CODE_ZERO) begin
      lvl = '0;
    end else if (!sel) begin
      lvl.atten = 1'h0;
      if (code[`PGC_SAT_MSB:`PGC_SAT_LSB] == `PGC_RX_SAT_PREFIX) begin
        lvl.steps = `PGC_RX_GAIN_MAX;
      end else begin
        lvl.steps = code;
      end
    end else begin
      lvl.atten = 1'h1;
      lvl.steps = code;
    end
    return lvl;
  endfunction

  // Transmit fine path: steps of 0.1 dB, full code range in both directions.
  function automatic pgc_pkg::pgc_level_type tx_decode(
    input logic       sel,
    input logic [3:0] code
  );
    pgc_pkg::pgc_level_type lvl;
    lvl = '0;
    if (code == `PGC_CODE_ZERO) begin
      lvl = '0;
    end else begin
      lvl.atten = sel;
      lvl.steps = code;
    end
    return lvl;
  endfunction

  // Address match shared by the write strobes and the assertions.
  function automatic logic addr_hit(
    input logic [`PGC_ADDR_W-1:0] addr,
    input logic [`PGC_ADDR_W-1:0] ofs
  );
    return addr == ofs;
  endfunction

  //----------------------------------------------------------------------------
  // Register storage
  //----------------------------------------------------------------------------

  logic [`PGC_DATA_W-1:0] rx_coarse_gain_ctrl;
  logic [`PGC_DATA_W-1:0] tx_fine_gain_ctrl;
  logic                   rx_coarse_atten_sel;
  logic [3:0]             rx_coarse_step_code;
  logic                   tx_fine_atten_sel;
  logic [3:0]             tx_fine_step_code;

  // Reserved bits are masked on write so they always hold zero.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_coarse_gain_ctrl <= `PGC_REG_RESET;
    end else if (WR_EN && addr_hit(ADDR, `PGC_RX_COARSE_OFS)) begin
      rx_coarse_gain_ctrl <= WR_DATA & `PGC_WMASK;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_fine_gain_ctrl <= `PGC_REG_RESET;
    end else if (WR_EN && addr_hit(ADDR, `PGC_TX_FINE_OFS)) begin
      tx_fine_gain_ctrl <= WR_DATA & `PGC_WMASK;
    end
  end

  assign rx_coarse_atten_sel = rx_coarse_gain_ctrl[`PGC_SEL_BIT];
  assign rx_coarse_step_code = rx_coarse_gain_ctrl[`PGC_CODE_MSB:`PGC_CODE_LSB];
  assign tx_fine_atten_sel   = tx_fine_gain_ctrl[`PGC_SEL_BIT];
  assign tx_fine_step_code   = tx_fine_gain_ctrl[`PGC_CODE_MSB:`PGC_CODE_LSB];

  //----------------------------------------------------------------------------
  // Read port
  //----------------------------------------------------------------------------

  // Read data follows the address one cycle later; unmapped addresses read zero.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RD_DATA <= `PGC_REG_RESET;
    end else begin
      unique case (ADDR)
        `PGC_RX_COARSE_OFS: RD_DATA <= rx_coarse_gain_ctrl;
        `PGC_TX_FINE_OFS:   RD_DATA <= tx_fine_gain_ctrl;
        default:            RD_DATA <= `PGC_REG_RESET;
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // Level outputs
  //----------------------------------------------------------------------------

  // Levels lag a write by two edges: the register first, then the decode.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RX_LEVEL <= '0;
    end else begin
      RX_LEVEL <= rx_decode(rx_coarse_atten_sel, rx_coarse_step_code);
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      TX_LEVEL <= '0;
    end else begin
      TX_LEVEL <= tx_decode(tx_fine_atten_sel, tx_fine_step_code);
    end
  end

  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  rx_gain_dir_a: assert property (
    (!rx_coarse_atten_sel && rx_coarse_step_code != 4'h0) |=> !RX_LEVEL.atten)
    else $error("Receive gain code did not give gain.");

  rx_atten_dir_a: assert property (
    (rx_coarse_atten_sel && rx_coarse_step_code != 4'h0) |=> RX_LEVEL.atten)
    else $error("Receive attenuation code did not attenuate.");

  rx_gain_linear_a: assert property (
    (!rx_coarse_atten_sel
      && rx_coarse_step_code[`PGC_SAT_MSB:`PGC_SAT_LSB] != `PGC_RX_SAT_PREFIX)
      |=> RX_LEVEL.steps == $past(rx_coarse_step_code))
    else $error("Receive gain steps do not follow the code.");

  rx_zero_flat_a: assert property (
    rx_coarse_step_code == 4'h0 |=> RX_LEVEL == 5'h00)
    else $error("Receive zero code changed the level.");

  rx_gain_sat_a: assert property (
    (!rx_coarse_atten_sel
      && rx_coarse_step_code[`PGC_SAT_MSB:`PGC_SAT_LSB] == `PGC_RX_SAT_PREFIX)
      |=> RX_LEVEL.steps == `PGC_RX_GAIN_MAX)
    else $error("Receive gain did not saturate at twelve steps.");

  rx_atten_range_a: assert property (
    (rx_coarse_atten_sel && rx_coarse_step_code == `PGC_CODE_FULL)
      |=> RX_LEVEL.steps == `PGC_CODE_FULL)
    else $error("Receive full attenuation not fifteen steps.");

  rx_gain_one_a: assert property (
    (!rx_coarse_atten_sel && rx_coarse_step_code == `PGC_CODE_ONE)
      |=> RX_LEVEL == {1'h0, `PGC_CODE_ONE})
    else $error("Receive gain code one did not give one step.");

  rx_atten_one_a: assert property (
    (rx_coarse_atten_sel && rx_coarse_step_code == `PGC_CODE_ONE)
      |=> RX_LEVEL == {1'h1, `PGC_CODE_ONE})
    else $error("Receive attenuation code one did not give one step.");

  rx_atten_linear_a: assert property (
    rx_coarse_atten_sel
      |=> RX_LEVEL.steps == $past(rx_coarse_step_code))
    else $error("Receive attenuation steps do not follow the code.");

  rx_gain_cap_a: assert property (
    !RX_LEVEL.atten
      |-> RX_LEVEL.steps <= `PGC_RX_GAIN_MAX)
    else $error("Receive gain exceeds twelve steps.");

  rx_level_hold_a: assert property (
    $stable(rx_coarse_gain_ctrl)
      |=> $stable(RX_LEVEL))
    else $error("Receive level moved without a register change.");

  //----------------------------------------------------------------------------
  // Transmit level assertions
  //----------------------------------------------------------------------------

  tx_dir_a: assert property (
    tx_fine_step_code != 4'h0 |=> TX_LEVEL.atten == $past(tx_fine_atten_sel))
    else $error("Transmit direction does not follow the select bit.");

  tx_steps_a: assert property (
    1'b1 |=> TX_LEVEL.steps == $past(tx_fine_step_code))
    else $error("Transmit steps do not follow the code.");

  tx_zero_flat_a: assert property (
    tx_fine_step_code == 4'h0 |=> TX_LEVEL == 5'h00)
    else $error("Transmit zero code changed the level.");

  tx_gain_full_a: assert property (
    (WR_EN && addr_hit(ADDR, `PGC_TX_FINE_OFS)
      && WR_DATA[`PGC_SEL_BIT:`PGC_CODE_LSB] == `PGC_TX_FULL_GAIN)
      |=> ##1 (TX_LEVEL == `PGC_TX_FULL_GAIN))
    else $error("Transmit full gain write not applied.");

  tx_atten_full_a: assert property (
    (WR_EN && addr_hit(ADDR, `PGC_TX_FINE_OFS)
      && WR_DATA[`PGC_SEL_BIT:`PGC_CODE_LSB] == `PGC_TX_FULL_ATTEN)
      |=> ##1 (TX_LEVEL == `PGC_TX_FULL_ATTEN))
    else $error("Transmit full attenuation write not applied.");

  tx_gain_one_a: assert property (
    (!tx_fine_atten_sel && tx_fine_step_code == `PGC_CODE_ONE)
      |=> TX_LEVEL == {1'h0, `PGC_CODE_ONE})
    else $error("Transmit gain code one did not add one step.");

  tx_atten_one_a: assert property (
    (tx_fine_atten_sel && tx_fine_step_code == `PGC_CODE_ONE)
      |=> TX_LEVEL == {1'h1, `PGC_CODE_ONE})
    else $error("Transmit attenuation code one did not cut one step.");

  tx_level_hold_a: assert property (
    $stable(tx_fine_gain_ctrl)
      |=> $stable(TX_LEVEL))
    else $error("Transmit level moved without a register change.");

  //----------------------------------------------------------------------------
  // Register port assertions
  //----------------------------------------------------------------------------

  rsvd_zero_a: assert property (
    (addr_hit(ADDR, `PGC_RX_COARSE_OFS) || addr_hit(ADDR, `PGC_TX_FINE_OFS))
      |=> RD_DATA[`PGC_RSVD_MSB:`PGC_RSVD_LSB] == `PGC_RSVD_ZERO)
    else $error("Reserved bits read back nonzero.");

  rx_write_a: assert property (
    (WR_EN && addr_hit(ADDR, `PGC_RX_COARSE_OFS))
      |=> rx_coarse_gain_ctrl == ($past(WR_DATA) & `PGC_WMASK))
    else $error("Receive register did not take the masked write.");

  tx_write_a: assert property (
    (WR_EN && addr_hit(ADDR, `PGC_TX_FINE_OFS))
      |=> tx_fine_gain_ctrl == ($past(WR_DATA) & `PGC_WMASK))
    else $error("Transmit register did not take the masked write.");

  rx_hold_a: assert property (
    !(WR_EN && addr_hit(ADDR, `PGC_RX_COARSE_OFS))
      |=> $stable(rx_coarse_gain_ctrl))
    else $error("Receive register changed without its write.");

  tx_hold_a: assert property (
    !(WR_EN && addr_hit(ADDR, `PGC_TX_FINE_OFS))
      |=> $stable(tx_fine_gain_ctrl))
    else $error("Transmit register changed without its write.");

  rsvd_store_a: assert property (
    rx_coarse_gain_ctrl[`PGC_RSVD_MSB:`PGC_RSVD_LSB] == `PGC_RSVD_ZERO
      && tx_fine_gain_ctrl[`PGC_RSVD_MSB:`PGC_RSVD_LSB] == `PGC_RSVD_ZERO)
    else $error("Reserved register bits hold ones.");

  rx_read_a: assert property (
    addr_hit(ADDR, `PGC_RX_COARSE_OFS)
      |=> RD_DATA == $past(rx_coarse_gain_ctrl))
    else $error("Receive register read back wrong.");

  tx_read_a: assert property (
    addr_hit(ADDR, `PGC_TX_FINE_OFS)
      |=> RD_DATA == $past(tx_fine_gain_ctrl))
    else $error("Transmit register read back wrong.");

  unmapped_read_a: assert property (
    !(addr_hit(ADDR, `PGC_RX_COARSE_OFS) || addr_hit(ADDR, `PGC_TX_FINE_OFS))
      |=> RD_DATA == `PGC_REG_RESET)
    else $error("Unmapped address read back nonzero.");

endmodule

`default_nettype wire

// File: verification/pgc_regs_test.sv
// Self-checking testbench for the path gain control register bank.
`timescale 1ns/1ps
`default_nettype none
`include "pgc_consts.svh"

module pgc_regs_test;

  //----------------------------------------------------------------------------
  // Signals and design instance
  //----------------------------------------------------------------------------
  logic                   clk        = 1'b0;
  logic                   resetn     = 1'b0;
  logic [7:0]             addr       = 8'h00;
  logic                   wr_en      = 1'b0;
  logic [7:0]             wr_data    = 8'h00;
  logic [7:0]             rd_data;
  pgc_pkg::pgc_level_type rx_level;
  pgc_pkg::pgc_level_type tx_level;
  int                     n_mismatch = 0;
  int                     num_checks = 0;
  logic                   sel;
  logic [3:0]             code;
  logic [3:0]             rx_steps;

  always #50 clk = ~clk;

  pgc_regs i_pgc_regs (
    .CLK      (clk),
    .RESETN   (resetn),
    .ADDR     (addr),
    .WR_EN    (wr_en),
    .WR_DATA  (wr_data),
    .RD_DATA  (rd_data),
    .RX_LEVEL (rx_level),
    .TX_LEVEL (tx_level)
  );

  //----------------------------------------------------------------------------
  // Access and compare tasks
  //----------------------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk5(input logic [4:0] got, input logic [4:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr    = a;
    wr_en   = 1'b1;
    wr_data = d;
    @(negedge clk);
    wr_en   = 1'b0;
  endtask

  // Read data is registered, so it is looked at one full cycle after ADDR is set.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    chk8(rd_data, exp);
  endtask

  task automatic check_zero();
    chk5(rx_level, 5'h00);
    chk5(tx_level, 5'h00);
    rd(`PGC_RX_COARSE_OFS, 8'h00);
    rd(`PGC_TX_FINE_OFS, 8'h00);
  endtask

  task automatic tally_and_finish();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  //----------------------------------------------------------------------------
  // Tests
  //----------------------------------------------------------------------------
  initial begin
    #300000;
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    check_zero();
    // Every select and code on both paths, with the reserved bits written as 3'h7 on receive and 3'h5 on transmit.
    for (int i = 0; i < 32; i++) begin
      sel      = i[4];
      code     = i[3:0];
      rx_steps = (!sel && code[3:2] == `PGC_RX_SAT_PREFIX) ? `PGC_RX_GAIN_MAX : code;
      wr(`PGC_RX_COARSE_OFS, {3'h7, sel, code});
      wr(`PGC_TX_FINE_OFS, {3'h5, ~sel, ~code});
      @(negedge clk);
      chk5(rx_level, (code == 4'h0) ? 5'h00 : {sel, rx_steps});
      chk5(tx_level, (code == 4'hF) ? 5'h00 : {~sel, ~code});
      rd(`PGC_RX_COARSE_OFS, {3'h0, sel, code});
      rd(`PGC_TX_FINE_OFS, {3'h0, ~sel, ~code});
    end
    // Writes to neighbouring addresses must not reach either register.
    wr(8'h26, 8'h15);
    wr(8'h29, 8'h15);
    rd(8'h29, 8'h00);
    rd(`PGC_RX_COARSE_OFS, 8'h1F);
    rd(`PGC_TX_FINE_OFS, 8'h00);
    // A reset in mid-run returns both paths to 0 dB.
    wr(`PGC_TX_FINE_OFS, 8'h13);
    @(negedge clk);
    chk5(tx_level, 5'h13);
    resetn = 1'b0;
    @(negedge clk);
    resetn = 1'b1;
    check_zero();
    tally_and_finish();
  end

endmodule
`default_nettype wire
